// ---- src/setw_pkg.sv ----
// Purpose: Shared constants for the two-wire serial memory host controller.
// Assumes: 200 MHz system clock, bus clock made here by division.
// Notes:   Times are kept in their own units; cycle counts derive from them.
package setw_pkg;

  // ------------------------------------------------------------------
  // Clock and bus timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 2500;   // 400 kHz bus clock
  // Quarter of a bus clock, rounded up so the bus never runs fast
  localparam int QUARTER_CYC =
    (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  // Longest self-timed program cycle of the memory
  localparam int PROG_TIME_US = 4000;
  localparam int PROG_TIME_CYC = PROG_TIME_US * 1000 / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // Protocol fields
  // ------------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;  // Fixed upper nibble
  localparam logic [3:0] ACK_BIT       = 4'h8;  // Ninth bit of a word
  localparam logic [3:0] RECOV_CLOCKS  = 4'h9;  // Bus-free clocks
  localparam int         WADDR_W       = 10;

  // Command codes on cmd_op_i
  localparam logic [1:0] OP_WRITE     = 2'h0;
  localparam logic [1:0] OP_READ_CUR  = 2'h1;
  localparam logic [1:0] OP_READ_RAND = 2'h2;
  localparam logic [1:0] OP_RECOVER   = 2'h3;

  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DEV, ST_WADDR, ST_WDATA, ST_RDATA, ST_STOP,
    ST_RECOV
  } setw_state_t;

endpackage : setw_pkg

// ---- src/setw_sync2.sv ----
// Purpose: Two-flop synchroniser for an asynchronous pin.
// Assumes: Input idles high, as an open-drain line does.
// Notes:   Only the second flop is visible outside.
`timescale 1ns/100ps
`default_nettype none
module setw_sync2 (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);

  logic meta_reg;
  logic meta_next;
  logic q_reg;
  logic q_next;

  // ------------------------------------------------------------------
  // Synchroniser chain
  // ------------------------------------------------------------------
  always_comb begin
    meta_next = d_i;
    q_next    = meta_reg;
  end

  // Reset to the idle level of the line
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b1;
      q_reg    <= 1'b1;
    end else begin
      meta_reg <= meta_next;
      q_reg    <= q_next;
    end
  end

  assign q_o = q_reg;

endmodule : setw_sync2
`default_nettype wire

// ---- src/setw_qtick.sv ----
// Purpose: Free-running divider giving a one-cycle quarter-bit enable.
// Assumes: DIV of at least 2.
// Notes:   Runs continuously so bus phases are equal, except the first after idle and a write-data wait.
`timescale 1ns/100ps
`default_nettype none
module setw_qtick #(
  parameter int DIV = 125
) (
  input  wire logic mclk_i,
  input  wire logic rst_i,
  output logic      tick_o
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          tick_reg;
  logic          tick_next;

  // ------------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------------
  always_comb begin
    tick_next = (cnt_reg == LAST);
    cnt_next  = tick_next ? '0 : cnt_reg + 1'b1;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule : setw_qtick
`default_nettype wire

// ---- src/setw_host.sv ----
// Purpose: Host controller driving a two-wire serial memory by its pins.
// Assumes: Sole bus master; SCL is push-pull, SDA open-drain.
// Notes:   Each bit is four quarter phases: low, low(change), high, high.
`timescale 1ns/100ps
`default_nettype none
module setw_host
  import setw_pkg::*;
#(
  parameter int ADDR_BITS  = 10,
  parameter int PAGE_BYTES = 16,
  parameter int LEN_W      = 8,
  parameter int PROG_CYC   = PROG_TIME_CYC
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             cmd_valid_i,
  output logic                  cmd_ready_o,
  input  wire logic [1:0]       cmd_op_i,
  input  wire logic [2:0]       cmd_dsel_i,
  input  wire logic [9:0]       cmd_addr_i,
  input  wire logic [LEN_W-1:0] cmd_len_i,
  input  wire logic [7:0]       wr_data_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  output logic [7:0]            rd_data_o,
  output logic                  rd_valid_o,
  output logic                  done_o,
  output logic                  err_o,
  output logic                  scl_o,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_o
);

  localparam int PTW = $clog2(PROG_CYC + 1);
  localparam logic [PTW-1:0] PT_LIMIT = PTW'(PROG_CYC);
  localparam logic [LEN_W-1:0] PAGE_LAST = LEN_W'(PAGE_BYTES - 1);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  setw_state_t      st_reg,    st_next;
  logic [1:0]       ph_reg,    ph_next;
  logic [3:0]       bit_reg,   bit_next;
  logic [7:0]       shf_reg,   shf_next;
  logic [LEN_W-1:0] cnt_reg,   cnt_next;
  logic             rdsel_reg, rdsel_next;
  logic             poll_reg,  poll_next;
  logic             npoll_reg, npoll_next;
  logic             ack_reg,   ack_next;
  logic             err_reg,   err_next;
  logic             ld_reg,    ld_next;
  logic [1:0]       op_reg,    op_next;
  logic [2:0]       dsel_reg,  dsel_next;
  logic [9:0]       addr_reg,  addr_next;
  logic [PTW-1:0]   ptim_reg,  ptim_next;
  logic             scl_reg,   scl_next;
  logic             oe_reg,    oe_next;
  logic [7:0]       rdd_reg,   rdd_next;
  logic             rdv_reg,   rdv_next;
  logic             done_reg,  done_next;
  logic             tick;
  logic             sda_s;
  logic             sample;
  logic             bit_end;
  logic             is_tx;

  setw_qtick #(.DIV(QUARTER_CYC)) u_tick (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  // SDA comes back from the bus and crosses in here
  setw_sync2 u_sda (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .d_i    (sda_i),
    .q_o    (sda_s)
  );

  // Device word: type code, strap or page bits, direction
  function automatic logic [7:0] dev_word(input logic [2:0] ds,
                                          input logic [9:0] ad,
                                          input logic       rd);
    logic [2:0] low;
    low = ds;
    if (ADDR_BITS == 9) begin
      low = {ds[2:1], ad[8]};
    end else if (ADDR_BITS == 10) begin
      low = {ds[2], ad[9:8]};
    end
    return {DEV_TYPE_CODE, low, rd};
  endfunction : dev_word

  // ------------------------------------------------------------------
  // Sequencer: next values
  // ------------------------------------------------------------------
  always_comb begin
    st_next    = st_reg;
    ph_next    = ph_reg;
    bit_next   = bit_reg;
    shf_next   = shf_reg;
    cnt_next   = cnt_reg;
    rdsel_next = rdsel_reg;
    poll_next  = poll_reg;
    npoll_next = npoll_reg;
    ack_next   = ack_reg;
    err_next   = err_reg;
    ld_next    = ld_reg;
    op_next    = op_reg;
    dsel_next  = dsel_reg;
    addr_next  = addr_reg;
    rdd_next   = rdd_reg;
    rdv_next   = 1'b0;
    done_next  = 1'b0;
    sample     = tick && (ph_reg == 2'd2);
    bit_end    = tick && (ph_reg == 2'd3);
    // Program-time watchdog runs only while polling
    ptim_next  = (poll_reg && ptim_reg != PT_LIMIT) ? ptim_reg + 1'b1
                                                    : ptim_reg;
    if (tick && !(st_reg == ST_WDATA && bit_reg == 4'h0 &&
                  ph_reg == 2'd0 && !ld_reg)) begin
      ph_next = ph_reg + 2'd1;
    end
    unique case (st_reg)
      ST_IDLE: begin
        ph_next = 2'd0;
        if (cmd_valid_i) begin
          op_next    = cmd_op_i;
          dsel_next  = cmd_dsel_i;
          addr_next  = cmd_addr_i;
          // A write never runs past one page
          cnt_next   = (cmd_op_i == OP_WRITE && cmd_len_i > PAGE_LAST)
                       ? PAGE_LAST : cmd_len_i;
          rdsel_next = (cmd_op_i == OP_READ_CUR);
          poll_next  = 1'b0;
          npoll_next = 1'b0;
          err_next   = 1'b0;
          ptim_next  = '0;
          bit_next   = 4'h0;
          st_next    = (cmd_op_i == OP_RECOVER) ? ST_RECOV : ST_START;
        end
      end
      ST_START: begin
        if (bit_end) begin
          bit_next = 4'h0;
          shf_next = dev_word(dsel_reg, addr_reg, rdsel_reg);
          st_next  = (op_reg == OP_RECOVER) ? ST_STOP : ST_DEV;
        end
      end
      ST_STOP: begin
        if (bit_end) begin
          if (npoll_reg) begin
            st_next    = ST_START;
            poll_next  = 1'b1;
            rdsel_next = 1'b0;
            npoll_next = 1'b0;
          end else begin
            st_next   = ST_IDLE;
            done_next = 1'b1;
          end
        end
      end
      ST_RECOV: begin
        if (sample && sda_s) begin
          st_next = ST_START;
          ph_next = 2'd0;
        end else if (bit_end) begin
          bit_next = bit_reg + 4'h1;
          if (bit_reg == RECOV_CLOCKS - 4'h1) begin
            st_next   = ST_IDLE;                     // Line stuck low
            err_next  = 1'b1;
            done_next = 1'b1;
          end
        end
      end
      ST_RDATA: begin
        if (sample && bit_reg < ACK_BIT) begin
          shf_next = {shf_reg[6:0], sda_s};
          if (bit_reg == 4'h7) begin
            rdd_next = {shf_reg[6:0], sda_s};
            rdv_next = 1'b1;
          end
        end
        if (bit_end) begin
          bit_next = bit_reg + 4'h1;
          if (bit_reg == ACK_BIT) begin
            bit_next = 4'h0;
            if (cnt_reg == '0) begin
              st_next = ST_STOP;
            end else begin
              cnt_next = cnt_reg - 1'b1;
            end
          end
        end
      end
      default: begin
        // Device word, word address and data bytes share the shifter
        if (st_reg == ST_WDATA && bit_reg == 4'h0 && ph_reg == 2'd0 &&
            !ld_reg) begin
          if (wr_valid_i) begin
            shf_next = wr_data_i;
            ld_next  = 1'b1;
          end
        end
        if (sample && bit_reg == ACK_BIT) begin
          ack_next = !sda_s;
        end
        if (bit_end && bit_reg < ACK_BIT) begin
          shf_next = {shf_reg[6:0], 1'b0};
          bit_next = bit_reg + 4'h1;
        end else if (bit_end) begin
          bit_next = 4'h0;
          if (st_reg == ST_DEV) begin
            if (ack_reg && rdsel_reg) begin
              st_next = ST_RDATA;
            end else if (ack_reg && poll_reg) begin
              st_next = ST_STOP;
            end else if (ack_reg) begin
              st_next  = ST_WADDR;
              shf_next = addr_reg[7:0];
            end else if (poll_reg && ptim_reg < PT_LIMIT) begin
              st_next    = ST_STOP;
              npoll_next = 1'b1;
            end else begin
              st_next  = ST_STOP;
              err_next = 1'b1;
            end
          end else if (!ack_reg) begin
            st_next  = ST_STOP;
            err_next = 1'b1;
          end else if (st_reg == ST_WADDR) begin
            ld_next = 1'b0;
            if (op_reg == OP_READ_RAND) begin
              st_next    = ST_START;
              rdsel_next = 1'b1;
            end else begin
              st_next = ST_WDATA;
            end
          end else begin
            ld_next = 1'b0;
            if (cnt_reg == '0) begin
              st_next    = ST_STOP;
              npoll_next = 1'b1;
            end else begin
              cnt_next = cnt_reg - 1'b1;
            end
          end
        end
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Pin levels: derived from the coming state, so they are registered
  // ------------------------------------------------------------------
  always_comb begin
    is_tx = (st_next == ST_DEV) || (st_next == ST_WADDR) ||
            (st_next == ST_WDATA);
    scl_next = ph_next[1];
    oe_next  = 1'b0;
    unique case (st_next)
      ST_IDLE:  scl_next = 1'b1;
      ST_START: begin
        scl_next = (ph_next == 2'd1) || (ph_next == 2'd2);
        oe_next  = ph_next[1];
      end
      ST_STOP: begin
        oe_next = (ph_next == 2'd1) || (ph_next == 2'd2);
      end
      ST_RECOV: oe_next = 1'b0;
      default: begin
        // SDA held while SCL falls, changed one quarter later
        if (ph_next == 2'd0) begin
          oe_next = oe_reg;
        end else if (is_tx) begin
          oe_next = (bit_next < ACK_BIT) && !shf_next[7];
        end else begin
          oe_next = (bit_next == ACK_BIT) && (cnt_next != '0);
        end
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_reg    <= ST_IDLE;
      ph_reg    <= 2'd0;
      bit_reg   <= 4'h0;
      shf_reg   <= 8'h00;
      cnt_reg   <= '0;
      rdsel_reg <= 1'b0;
      poll_reg  <= 1'b0;
      npoll_reg <= 1'b0;
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      ld_reg    <= 1'b0;
      op_reg    <= OP_WRITE;
      dsel_reg  <= 3'h0;
      addr_reg  <= 10'h000;
      ptim_reg  <= '0;
      scl_reg   <= 1'b1;
      oe_reg    <= 1'b0;
      rdd_reg   <= 8'h00;
      rdv_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      st_reg    <= st_next;
      ph_reg    <= ph_next;
      bit_reg   <= bit_next;
      shf_reg   <= shf_next;
      cnt_reg   <= cnt_next;
      rdsel_reg <= rdsel_next;
      poll_reg  <= poll_next;
      npoll_reg <= npoll_next;
      ack_reg   <= ack_next;
      err_reg   <= err_next;
      ld_reg    <= ld_next;
      op_reg    <= op_next;
      dsel_reg  <= dsel_next;
      addr_reg  <= addr_next;
      ptim_reg  <= ptim_next;
      scl_reg   <= scl_next;
      oe_reg    <= oe_next;
      rdd_reg   <= rdd_next;
      rdv_reg   <= rdv_next;
      done_reg  <= done_next;
    end
  end

  // Outputs; SDA is only ever pulled low
  assign cmd_ready_o = (st_reg == ST_IDLE);
  assign wr_ready_o  = (st_reg == ST_WDATA) && (bit_reg == 4'h0) &&
                       (ph_reg == 2'd0) && !ld_reg;
  assign rd_data_o   = rdd_reg;
  assign rd_valid_o  = rdv_reg;
  assign done_o      = done_reg;
  assign err_o       = err_reg;
  assign scl_o       = scl_reg;
  assign sda_o       = 1'b0;
  assign sda_oe_o    = oe_reg;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  chk_sda_stable_high: assert property (
    scl_reg && $past(scl_reg) &&
    !(st_reg inside {ST_START, ST_STOP, ST_IDLE}) |-> $stable(oe_reg))
    else $error("SDA moved while SCL high in a data bit");
  chk_start_shape: assert property (
    $rose(oe_reg) && scl_reg |-> st_reg == ST_START)
    else $error("SDA fell under SCL high outside a start");
  chk_stop_shape: assert property (
    $fell(oe_reg) && scl_reg && $past(scl_reg) |-> st_reg == ST_STOP)
    else $error("SDA rose under SCL high outside a stop");
  chk_dev_type_code: assert property (
    st_reg == ST_DEV && $past(st_reg) == ST_START
    |-> shf_reg[7:4] == DEV_TYPE_CODE)
    else $error("Device word lacks type code");
  chk_dir_bit: assert property (
    st_reg == ST_DEV && $past(st_reg) == ST_START
    |-> shf_reg[0] == rdsel_reg)
    else $error("Direction bit wrong");
  chk_ack_release: assert property (
    st_reg inside {ST_DEV, ST_WADDR, ST_WDATA} && bit_reg == ACK_BIT &&
    ph_reg != 2'd0 |-> !oe_reg)
    else $error("Host drove SDA in the memory's acknowledge slot");
  chk_read_ack: assert property (
    st_reg == ST_RDATA && bit_reg == ACK_BIT && ph_reg == 2'd2
    |-> oe_reg == (cnt_reg != '0))
    else $error("Read acknowledge does not match remaining count");
  chk_write_stop: assert property (
    st_reg == ST_WDATA && bit_end && bit_reg == ACK_BIT && ack_reg &&
    cnt_reg == '0 |=> st_reg == ST_STOP && npoll_reg)
    else $error("Last data byte not followed by stop and poll");
  chk_recov_count: assert property (
    st_reg == ST_RECOV |-> bit_reg < RECOV_CLOCKS)
    else $error("Recovery ran more than nine clocks");

  cov_write_poll: cover property (poll_reg && st_reg == ST_DEV &&
                                  bit_end && bit_reg == ACK_BIT && ack_reg);
  cov_random_read: cover property (op_reg == OP_READ_RAND && rdv_reg);
  cov_seq_read: cover property (st_reg == ST_RDATA && bit_reg == ACK_BIT
                                && oe_reg);
  cov_recover: cover property (op_reg == OP_RECOVER && done_reg &&
                               !err_reg);

endmodule : setw_host
`default_nettype wire

// ---- test/setw_mem_model.sv ----
// Purpose: Behavioural serial memory, largest variant, facing the host.
// Assumes: SDA has a pull-up outside; this model only pulls it low.
// Notes:   Bytes land at once; the program time only blocks access.
`timescale 1ns/100ps
`default_nettype none
module setw_mem_model #(
  parameter int TPROG_NS = 10000
) (
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic chip_select_strap_2_i,
  input  wire logic wp_i,
  output logic      sda_pull_o
);
  logic [7:0] mem [1024];
  logic [9:0] ptr;
  logic [7:0] sh, dout;
  logic [3:0] bc;
  logic [2:0] st;  // 0 idle, 1 device word, 2 address, 3 write, 4 read
  logic       busy, got;
  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = i[7:0] ^ 8'h5a;
    {ptr, st, bc, busy, got, sda_pull_o} = '0;
  end
  // Start and stop only while the clock is high
  always @(negedge sda_i) if (scl_i) begin
    st = 1; bc = 0; got = 0;
  end
  always @(posedge sda_i) if (scl_i) begin
    if (got && !wp_i) busy = 1;
    st = 0; got = 0;
  end
  // Program time blocks every access, polls included
  always @(posedge busy) #(TPROG_NS) busy = 0;
  // Sample on the rising edge; a missing host ack ends a read
  always @(posedge scl_i) if (st != 0) begin
    if (bc < 8) sh = {sh[6:0], sda_i};
    else if (st == 4 && sda_i) st = 0;
    bc = bc + 1;
  end
  // Change the line after the falling edge, and only ever pull low
  always @(negedge scl_i) if (st != 0) begin
    sda_pull_o = 0;
    if (bc == 8 && st != 4) begin
      case (st)
        1: if (sh[7:4] == 4'ha && sh[3] == chip_select_strap_2_i
               && !busy) begin
             st = sh[0] ? 3'd4 : 3'd2;
             if (!sh[0]) ptr[9:8] = sh[2:1];
             sda_pull_o = 1;
           end else st = 0;
        2: begin ptr[7:0] = sh; st = 3; sda_pull_o = 1; end
        default: begin
          if (!wp_i) mem[ptr] = sh;
          ptr[3:0] = ptr[3:0] + 4'h1; got = 1; sda_pull_o = 1;
        end
      endcase
    end else if (bc == 9) begin
      bc = 0;
      if (st == 4) begin dout = mem[ptr]; ptr = ptr + 10'h1; end
    end
    if (st == 4 && bc < 8) sda_pull_o = !dout[3'd7 - bc[2:0]];
  end
endmodule : setw_mem_model
`default_nettype wire

// ---- test/setw_host_tb_top.sv ----
// Purpose: Self-checking bench for the serial memory host controller.
// Assumes: Memory model strapped high, writes enabled.
// Notes:   Counts are small; each bus byte costs some 4500 cycles.
`timescale 1ns/100ps
`default_nettype none
module setw_host_tb_top;
  import setw_pkg::*;
  logic       mclk_i = 0, rst_i = 1, cmd_valid_i = 0, wr_valid_i = 0;
  logic [1:0] cmd_op_i = 0;
  logic [2:0] cmd_dsel_i = 0;
  logic [9:0] cmd_addr_i = 0, ad;
  logic [7:0] cmd_len_i = 0, wr_data_i = 0, rd_data_o, d;
  logic       cmd_ready_o, wr_ready_o, rd_valid_o, done_o, err_o;
  logic       scl_o, sda_o, sda_oe_o, pull;
  wire logic  sda = !(sda_oe_o || pull);  // Pull-up when all release
  int         err_count = 0, n_checks = 0, seed, pg;
  logic [7:0] exp_mem [1024];
  logic [7:0] wq [$], rq [$];
  always #2.5 mclk_i = ~mclk_i;
  setw_host #(.PROG_CYC(20000)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_op_i(cmd_op_i), .cmd_dsel_i(cmd_dsel_i), .cmd_addr_i(cmd_addr_i),
    .cmd_len_i(cmd_len_i), .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i),
    .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .done_o(done_o), .err_o(err_o), .scl_o(scl_o), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o));
  // Program time longer than one poll, so the first poll goes unanswered
  setw_mem_model #(.TPROG_NS(40000)) mem (.scl_i(scl_o), .sda_i(sda),
    .wp_i(1'b0),
    .chip_select_strap_2_i(1'b1), .sda_pull_o(pull));
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task close_out;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // One command; write bytes fed from wq, read bytes land in rq
  task run(input logic [1:0] op, input logic [2:0] ds,
           input logic [9:0] a, input logic [7:0] ln);
    int   n;
    logic acc, tw;
    rq = {};
    cmd_op_i = op; cmd_dsel_i = ds; cmd_addr_i = a; cmd_len_i = ln;
    cmd_valid_i = 1;
    for (n = 0; n < 40000; n++) begin
      acc = cmd_valid_i && cmd_ready_o;
      tw = wr_valid_i && wr_ready_o;
      @(posedge mclk_i);
      #1;
      if (acc) cmd_valid_i = 0;
      if (tw) void'(wq.pop_front());
      wr_valid_i = wq.size() > 0;
      wr_data_i = wq.size() > 0 ? wq[0] : 8'h00;
      if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
      if (done_o === 1'b1) break;
    end
    if (n == 40000) begin
      err_count++;
      close_out();
    end
  endtask : run
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hc09b79fd;
    for (int i = 0; i < 1024; i++) exp_mem[i] = i[7:0] ^ 8'h5a;
    repeat (16) @(posedge mclk_i);
    #1 rst_i = 0;
    run(OP_RECOVER, 3'h4, 10'h000, 8'h00);
    chk({7'h0, err_o}, 8'h00);
    // Wrong strap must go unanswered
    run(OP_READ_CUR, 3'h0, 10'h000, 8'h00);
    chk({7'h0, err_o}, 8'h01);
    // Two bytes from the last slot of a random page wrap in-page
    pg = $random(seed);
    ad = {pg[5:0], 4'hf};
    for (int i = 0; i < 2; i++) begin
      d = 8'($random(seed));
      wq.push_back(d);
      exp_mem[{pg[5:0], 4'(15 + i)}] = d;
    end
    run(OP_WRITE, 3'h4, ad, 8'h01);
    chk({7'h0, err_o}, 8'h00);
    run(OP_READ_RAND, 3'h4, {pg[5:0], 4'h0}, 8'h00);
    chk(8'(rq.size()), 8'h01);
    chk(rq[0], exp_mem[{pg[5:0], 4'h0}]);
    // Sequential read across the array end
    run(OP_READ_RAND, 3'h4, 10'h3ff, 8'h01);
    chk(rq[0], exp_mem[1023]);
    chk(rq[1], exp_mem[0]);
    run(OP_READ_CUR, 3'h4, 10'h000, 8'h00);
    chk(rq[0], exp_mem[1]);
    close_out();
  end
endmodule : setw_host_tb_top
`default_nettype wire
